//--- rtl/jbsp_port.v
// boundary-scan test access port sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
`include "jbsp_regs.vh"
module jbsp_port #(
  parameter NPINS = 8
) (
  // system clock and reset
  input wire clk,
  input wire rst,
  // test port pins
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire trst_n,
  output reg tdo,
  output reg tdo_oe,
  // core side of each user pin
  input wire [NPINS-1:0] core_out,
  input wire [NPINS-1:0] core_oe,
  output reg [NPINS-1:0] core_in,
  // pad side of each user pin
  input wire [NPINS-1:0] pad_in,
  output reg [NPINS-1:0] pad_out,
  output reg [NPINS-1:0] pad_oe,
  // configuration through the port in progress
  output reg config_active
);

  localparam BSR_LEN = 3 * NPINS;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  reg [3:0] sync1;
  reg [3:0] sync2;
  reg tck_d;
  // first stage read only by the second stage
  always @(posedge clk) begin
    if (rst) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      tck_d <= 1'b0;
    end else begin
      sync1 <= {trst_n, tdi, tms, tck};
      sync2 <= sync1;
      tck_d <= sync2[0];
    end
  end
  wire s_tms = sync2[1];
  wire s_tdi = sync2[2];
  wire s_trst_n = sync2[3];
  wire tck_rise = sync2[0] & ~tck_d;
  wire tck_fall = ~sync2[0] & tck_d;
  // test reset acts once trst_n has passed the two synchroniser stages, with no test clock edge needed
  wire test_rst = rst | ~s_trst_n;

  // ----------------------------------------
  // controller state machine
  // ----------------------------------------
  reg [3:0] state;
  reg [3:0] next_state;
  always @* begin
    next_state = state;
    case (state)
      `JBSP_S_RESET: next_state = s_tms ? `JBSP_S_RESET : `JBSP_S_IDLE;
      `JBSP_S_IDLE: next_state = s_tms ? `JBSP_S_SEL_DR : `JBSP_S_IDLE;
      `JBSP_S_SEL_DR: next_state = s_tms ? `JBSP_S_SEL_IR : `JBSP_S_CAP_DR;
      `JBSP_S_CAP_DR: next_state = s_tms ? `JBSP_S_EX1_DR : `JBSP_S_SH_DR;
      `JBSP_S_SH_DR: next_state = s_tms ? `JBSP_S_EX1_DR : `JBSP_S_SH_DR;
      `JBSP_S_EX1_DR: next_state = s_tms ? `JBSP_S_UPD_DR : `JBSP_S_PAU_DR;
      `JBSP_S_PAU_DR: next_state = s_tms ? `JBSP_S_EX2_DR : `JBSP_S_PAU_DR;
      `JBSP_S_EX2_DR: next_state = s_tms ? `JBSP_S_UPD_DR : `JBSP_S_SH_DR;
      `JBSP_S_UPD_DR: next_state = s_tms ? `JBSP_S_SEL_DR : `JBSP_S_IDLE;
      `JBSP_S_SEL_IR: next_state = s_tms ? `JBSP_S_RESET : `JBSP_S_CAP_IR;
      `JBSP_S_CAP_IR: next_state = s_tms ? `JBSP_S_EX1_IR : `JBSP_S_SH_IR;
      `JBSP_S_SH_IR: next_state = s_tms ? `JBSP_S_EX1_IR : `JBSP_S_SH_IR;
      `JBSP_S_EX1_IR: next_state = s_tms ? `JBSP_S_UPD_IR : `JBSP_S_PAU_IR;
      `JBSP_S_PAU_IR: next_state = s_tms ? `JBSP_S_EX2_IR : `JBSP_S_PAU_IR;
      `JBSP_S_EX2_IR: next_state = s_tms ? `JBSP_S_UPD_IR : `JBSP_S_SH_IR;
      `JBSP_S_UPD_IR: next_state = s_tms ? `JBSP_S_SEL_DR : `JBSP_S_IDLE;
      default: next_state = `JBSP_S_RESET;
    endcase
  end
  // five high mode select clocks from any state reach reset by this graph
  always @(posedge clk) begin
    if (test_rst) begin
      state <= `JBSP_S_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // instruction register and decode
  // ----------------------------------------
  reg [`JBSP_IR_LEN-1:0] ir_shift;
  reg [`JBSP_IR_LEN-1:0] ir;
  always @(posedge clk) begin
    if (test_rst) begin
      ir_shift <= `JBSP_IR_CAPTURE;
      ir <= `JBSP_OP_IDCODE;
    end else if (tck_rise) begin
      case (state)
        `JBSP_S_RESET: ir <= `JBSP_OP_IDCODE;
        `JBSP_S_CAP_IR: ir_shift <= `JBSP_IR_CAPTURE;
        // instruction bits enter from the serial input
        `JBSP_S_SH_IR: ir_shift <= {s_tdi, ir_shift[`JBSP_IR_LEN-1:1]};
        `JBSP_S_UPD_IR: ir <= ir_shift;
        default: ir <= ir;
      endcase
    end
  end
  // unknown codes fall back to bypass, as the standard expects
  wire op_bypass = (ir == `JBSP_OP_BYPASS) | (ir == `JBSP_OP_CLAMP) | (ir == `JBSP_OP_HIGHZ)
                   | (ir == `JBSP_OP_CONFIG);
  wire op_id = (ir == `JBSP_OP_IDCODE);
  wire op_user = (ir == `JBSP_OP_USERCODE);
  wire op_bsr = (ir == `JBSP_OP_SAMPLE) | (ir == `JBSP_OP_EXTEST);
  wire sel_bypass = ~(op_id | op_user | op_bsr);
  wire drive_test = (ir == `JBSP_OP_EXTEST) | (ir == `JBSP_OP_CLAMP);
  wire pins_off = (ir == `JBSP_OP_HIGHZ) | (ir == `JBSP_OP_CONFIG);

  // ----------------------------------------
  // data registers
  // ----------------------------------------
  reg bypass_bit;
  reg [31:0] id_shift;
  reg [BSR_LEN-1:0] bsr_shift;
  reg [BSR_LEN-1:0] bsr_upd;
  reg [BSR_LEN-1:0] capture_vec;
  // separate loop variables so each is written by one process only
  integer i;
  integer j;
  // each cell: bit 0 input capture, bit 1 output enable, bit 2 output value
  always @* begin
    capture_vec = {BSR_LEN{1'b0}};
    for (i = 0; i < NPINS; i = i + 1) begin
      capture_vec[3*i] = pad_in[i];
      capture_vec[3*i+1] = core_oe[i];
      capture_vec[3*i+2] = core_out[i];
    end
  end
  always @(posedge clk) begin
    if (test_rst) begin
      bypass_bit <= 1'b0;
      id_shift <= 32'h0000_0000;
      bsr_shift <= {BSR_LEN{1'b0}};
      bsr_upd <= {BSR_LEN{1'b0}};
    end else if (tck_rise) begin
      if (state == `JBSP_S_CAP_DR) begin
        bypass_bit <= 1'b0;
        id_shift <= op_user ? `JBSP_USERCODE_VAL : `JBSP_IDCODE_VAL;
        // capture only samples; pins keep their drive from the core or from bsr_upd
        if (op_bsr) bsr_shift <= capture_vec;
      end else if (state == `JBSP_S_SH_DR) begin
        if (sel_bypass) bypass_bit <= s_tdi;
        if (op_id | op_user) id_shift <= {s_tdi, id_shift[31:1]};
        if (op_bsr) bsr_shift <= {s_tdi, bsr_shift[BSR_LEN-1:1]};
      end else if (state == `JBSP_S_UPD_DR && op_bsr) begin
        bsr_upd <= bsr_shift;
      end
    end
  end

  // ----------------------------------------
  // serial output and pin muxing
  // ----------------------------------------
  wire shifting = (state == `JBSP_S_SH_DR) | (state == `JBSP_S_SH_IR);
  wire dr_out = sel_bypass ? bypass_bit : ((op_id | op_user) ? id_shift[0] : bsr_shift[0]);
  wire ser_out = (state == `JBSP_S_SH_IR) ? ir_shift[0] : dr_out;
  // output moves half a test clock after the capture edge, giving hold to the next device
  always @(posedge clk) begin
    if (test_rst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo <= ser_out;
      tdo_oe <= shifting;
    end
  end
  // pin side registered; core stays in charge unless a drive, highz or config instruction holds
  always @(posedge clk) begin
    if (rst) begin
      pad_out <= {NPINS{1'b0}};
      pad_oe <= {NPINS{1'b0}};
      core_in <= {NPINS{1'b0}};
      config_active <= 1'b0;
    end else begin
      config_active <= ~test_rst & (ir == `JBSP_OP_CONFIG);
      for (j = 0; j < NPINS; j = j + 1) begin
        core_in[j] <= pad_in[j];
        if (~test_rst & pins_off) begin
          pad_out[j] <= 1'b0;
          pad_oe[j] <= 1'b0;
        end else if (~test_rst & drive_test) begin
          pad_out[j] <= bsr_upd[3*j+2];
          pad_oe[j] <= bsr_upd[3*j+1];
        end else begin
          pad_out[j] <= core_out[j];
          pad_oe[j] <= core_oe[j];
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- rtl/jbsp_regs.vh
// constants for the boundary-scan test access port
`ifndef JBSP_REGS_VH
`define JBSP_REGS_VH
// ----------------------------------------
// instruction register
// ----------------------------------------
`define JBSP_IR_LEN 10
`define JBSP_IR_CAPTURE 10'h001
// instruction codes are arbitrary values except bypass
`define JBSP_OP_BYPASS 10'h3ff
`define JBSP_OP_IDCODE 10'h006
`define JBSP_OP_SAMPLE 10'h005
`define JBSP_OP_EXTEST 10'h00f
`define JBSP_OP_CLAMP 10'h00a
`define JBSP_OP_HIGHZ 10'h00b
`define JBSP_OP_USERCODE 10'h007
`define JBSP_OP_CONFIG 10'h002
// identity value is arbitrary
`define JBSP_IDCODE_VAL 32'h1234_5671
`define JBSP_USERCODE_VAL 32'hffff_ffff
// ----------------------------------------
// controller states
// ----------------------------------------
`define JBSP_S_RESET 4'h0
`define JBSP_S_IDLE 4'h1
`define JBSP_S_SEL_DR 4'h2
`define JBSP_S_CAP_DR 4'h3
`define JBSP_S_SH_DR 4'h4
`define JBSP_S_EX1_DR 4'h5
`define JBSP_S_PAU_DR 4'h6
`define JBSP_S_EX2_DR 4'h7
`define JBSP_S_UPD_DR 4'h8
`define JBSP_S_SEL_IR 4'h9
`define JBSP_S_CAP_IR 4'ha
`define JBSP_S_SH_IR 4'hb
`define JBSP_S_EX1_IR 4'hc
`define JBSP_S_PAU_IR 4'hd
`define JBSP_S_EX2_IR 4'he
`define JBSP_S_UPD_IR 4'hf
`endif

//--- tb/jbsp_port_assertions.sv
// checker for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module jbsp_port_chk #(
  parameter NPINS = 8
) (
  // system side
  input wire logic clk,
  input wire logic rst,
  // test port
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe,
  // pins
  input wire logic [NPINS-1:0] core_in,
  input wire logic [NPINS-1:0] pad_in,
  input wire logic [NPINS-1:0] pad_oe,
  input wire logic config_active
);
  // cycles since each test clock edge; saturates so a stopped clock reads as 15
  logic [3:0] fcnt;
  logic [3:0] rcnt;
  always_ff @(posedge clk) begin
    fcnt <= rst ? 4'hf : $fell(tck) ? 4'h1 : (fcnt == 4'hf ? fcnt : fcnt + 4'h1);
    rcnt <= rst ? 4'hf : $rose(tck) ? 4'h1 : (rcnt == 4'hf ? rcnt : rcnt + 4'h1);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rise;
    $rose(tck) ##0 trst_n;
  endsequence
  sequence s_test_reset;
    !trst_n [*6];
  endsequence
  a_tdo_on_fall: assert property (!$past(rst) && trst_n && $changed(tdo) |-> fcnt inside {[1:5]})
    else $error("tdo moved away from a tck fall");
  a_oe_on_fall: assert property (!$past(rst) && trst_n && $past(trst_n, 4) && $changed(tdo_oe) |-> fcnt inside {[1:5]})
    else $error("tdo enable moved away from a tck fall");
  a_tdo_hold_rise: assert property (s_rise |-> $stable(tdo) [*4])
    else $error("tdo moved after a tck rise");
  a_quiet_idle: assert property (trst_n && $past(trst_n, 4) && fcnt == 4'hf && rcnt == 4'hf |-> $stable(config_active) && $stable(tdo_oe))
    else $error("state moved with tck stopped");
  a_reset_oe: assert property (s_test_reset |-> !tdo_oe)
    else $error("tdo enabled during test reset");
  a_reset_cfg: assert property (s_test_reset |-> !config_active)
    else $error("config mode during test reset");
  a_cfg_pins: assert property (config_active && $past(config_active, 3) |-> pad_oe == '0)
    else $error("pin driven while configuring");
  a_core_in: assert property (!$past(rst) |-> core_in == $past(pad_in))
    else $error("core input disturbed");
endmodule
bind jbsp_port jbsp_port_chk #(.NPINS(NPINS)) jbsp_port_chk_inst (.clk(clk), .rst(rst), .tck(tck), .trst_n(trst_n),
  .tdo(tdo), .tdo_oe(tdo_oe), .core_in(core_in), .pad_in(pad_in), .pad_oe(pad_oe), .config_active(config_active));
`default_nettype wire

//--- tb/jbsp_host.sv
// model of the outside test controller that drives the scan pins
`timescale 1ns/1ps
`default_nettype none
module jbsp_host (
  // pacing clock
  input wire logic clk,
  // test port pins
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // a released tdo is read as the inverse of its last value, never a kind guess
  wire line = tdo_oe ? tdo : ~tdo;
  // test reset held low until a test starts; tck stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst_n = 1'b0;
  end
  // one tck period of 16 cycles; tms and tdi settle half a period before the rise
  task step(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    repeat (8) @(posedge clk);
    tck <= 1'b1;
    o = line;
    repeat (8) @(posedge clk);
    tck <= 1'b0;
  endtask
  // idle to shift, n bits lsb first, update, idle; single device so position one
  task scan(input logic ir, input logic [31:0] din, input int n, output logic [31:0] dout);
    logic o;
    dout = 32'h0000_0000;
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
  // five high mode clocks then one low lands in idle
  task tap_reset;
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
endmodule
`default_nettype wire

//--- tb/test_jtag_boundary_scan_port.sv
// testbench for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
`include "jbsp_regs.vh"
module test_jtag_boundary_scan_port;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] core_out = 8'h00;
  logic [7:0] core_oe = 8'h00;
  logic [7:0] pad_in = 8'h00;
  wire tck, tms, tdi, trst_n, tdo, tdo_oe, config_active;
  wire [7:0] core_in, pad_out, pad_oe;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] got;
  initial forever #5 clk = ~clk;
  jbsp_port #(.NPINS(8)) jbsp_port_inst (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe), .core_in(core_in), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .config_active(config_active));
  jbsp_host jbsp_host_inst (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("%0d checks, %0d wrong", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // a hung scan would otherwise never end; the whole run needs about 2700 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      stop_test;
    end
  end
  task t_idcode;
    jbsp_host_inst.tap_reset;
    jbsp_host_inst.scan(1'b0, 32'h0000_0000, 32, got);
    check(got, `JBSP_IDCODE_VAL);
    check(32'(tdo_oe), 32'h0000_0000);
    $display("idcode test done");
  endtask
  task t_bypass;
    jbsp_host_inst.scan(1'b1, 32'(`JBSP_OP_BYPASS), 10, got);
    check(got, 32'(`JBSP_IR_CAPTURE));
    jbsp_host_inst.scan(1'b0, 32'h0000_00b6, 8, got);
    check(got, 32'h0000_006c);
    $display("bypass test done");
  endtask
  // capture with sample, preload a pattern, then drive it with extest
  task t_sample_drive;
    logic [23:0] e;
    core_out <= 8'ha5;
    core_oe <= 8'h3c;
    pad_in <= 8'h96;
    jbsp_host_inst.scan(1'b1, 32'(`JBSP_OP_SAMPLE), 10, got);
    for (int i = 0; i < 8; i++) e[3*i +: 3] = {core_out[i], core_oe[i], pad_in[i]};
    jbsp_host_inst.scan(1'b0, 32'h00c3_5af0, 24, got);
    check(got, 32'(e));
    check({pad_oe, pad_out, core_in}, {core_oe, core_out, pad_in});
    jbsp_host_inst.scan(1'b1, 32'(`JBSP_OP_EXTEST), 10, got);
    repeat (4) @(posedge clk);
    e = 24'hc3_5af0;
    // cell bit 3i+2 is the forced value, bit 3i+1 the forced enable
    for (int i = 0; i < 8; i++) check({pad_out[i], pad_oe[i]}, 32'(e[3*i+1 +: 2]));
    $display("sample and drive test done");
  endtask
  // release pins with highz then config, then clear with test reset
  task t_release;
    logic [9:0] codes [2] = '{`JBSP_OP_HIGHZ, `JBSP_OP_CONFIG};
    for (int k = 0; k < 2; k++) begin
      jbsp_host_inst.scan(1'b1, 32'(codes[k]), 10, got);
      repeat (4) @(posedge clk);
      check({config_active, pad_oe}, {k == 1, 8'h00});
    end
    jbsp_host_inst.trst_n <= 1'b0;
    repeat (10) @(posedge clk);
    check({config_active, tdo_oe}, 32'h0000_0000);
    jbsp_host_inst.trst_n <= 1'b1;
    $display("release test done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    jbsp_host_inst.trst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_idcode;
    t_bypass;
    t_sample_drive;
    t_release;
    stop_test;
  end
endmodule
`default_nettype wire
